// file: include/tpw_regs.svh
// Register offsets, field positions and constants of the PWM channel
`ifndef TPW_REGS_SVH
`define TPW_REGS_SVH

// ==========================================================
// Register byte offsets
`define TPW_ADR_MODE    8'h00
`define TPW_ADR_START   8'h04
`define TPW_ADR_DATA    8'h08
`define TPW_ADR_IRQ     8'h0c
`define TPW_ADR_STAT    8'h10

// ==========================================================
// Reset values and field codes
`define TPW_MODE_RST    8'h00
`define TPW_DATA_RST    16'h0000
`define TPW_OPM_TIMER   2'b00
`define TPW_OPM_EVENT   2'b01
`define TPW_OPM_PWM     2'b11
`define TPW_TRIG_EXT    1
`define TPW_TRIG_POL    0

// ==========================================================
// Modulator periods in count units
`define TPW_PER16       16'hffff
`define TPW_PER8        16'h00ff

// ==========================================================
// Count source divider masks
`define TPW_DIV_W       9
`define TPW_MASK2       9'h001
`define TPW_MASK16      9'h00f
`define TPW_MASK64      9'h03f
`define TPW_MASK512     9'h1ff

`endif

// file: include/tpw_pkg.sv
// Types shared by the PWM channel modules
package tpw_pkg;

    // Mode configuration byte, bit 7 down to bit 0
    typedef struct packed {
        logic [1:0] src;
        logic       wide8;
        logic [1:0] trig;
        logic       rsv;
        logic [1:0] opm;
    } tpw_mode_t;

    typedef enum logic [0:0] {
        TPW_STOP,
        TPW_RUN
    } tpw_state_t;

endpackage

// file: rtl/tpw_clk_div.sv
// Count source divider: one-cycle tick at clk/2, /16, /64 or /512
`timescale 1ns/100ps
`default_nettype none
`include "tpw_regs.svh"

module tpw_clk_div
    import tpw_pkg::*;
#(
    parameter int DIV_W = `TPW_DIV_W
)(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] src_i,
    output var  logic       tick_o
);

    logic [DIV_W-1:0] div_r;
    logic [DIV_W-1:0] mask;

    function automatic logic [DIV_W-1:0] src_mask(input logic [1:0] s);
        case (s)
            2'b00:   src_mask = DIV_W'(`TPW_MASK2);
            2'b01:   src_mask = DIV_W'(`TPW_MASK16);
            2'b10:   src_mask = DIV_W'(`TPW_MASK64);
            default: src_mask = DIV_W'(`TPW_MASK512);
        endcase
    endfunction

    assign mask = src_mask(src_i); // see R01

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_r  <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            div_r  <= div_r + 1'b1;
            tick_o <= ((div_r & mask) == mask); // see R01
        end
    end

endmodule // tpw_clk_div
`default_nettype wire

// file: rtl/tpw_pwm_top.sv
// PWM mode channel of a 16-bit timer with Wishbone register access
//
// Contract
// R01 - Count source select picks clock divided by 2, 16, 64 or 512.
// R02 - Trigger select 00/01 means software trigger, 10/11 means pin.
// R03 - Internal trigger fires when software writes one to start bit.
// R04 - Pin trigger on falling edge, or rising edge when bit 3 is one.
// R05 - Pin edges count only while the start bit is one.
// R06 - Triggers during pulse output are ignored.
// R07 - Selecting PWM mode drives the pulse output low.
// R08 - Accepted trigger starts down-counting and pulse output.
// R09 - Every high-to-low output edge sets the request bit, held till cleared. Leaving PWM mode drops the output without setting it.
// R10 - At each rising edge reload counter from reload value and continue.
// R11 - Width bit zero: period 65535 units, high time n units.
// R12 - Width bit one: prescale m+1, period (m+1)*255, high n*(m+1).
// R13 - Zero modulator value: no run, output low, no request.
// R14 - In 8-bit mode first hold output low for the high time.
// R15 - Data write when stopped loads reload and counter, else reload only.
// R16 - Software must not rely on reading the data register.
// R17 - Clearing start stops; a high output falls and sets the request.
// R18 - Switching into PWM from reset, timer or event mode sets request.
// R19 - Software clears the request bit after selecting the mode.
// R20 - Software sets the trigger pin as input before using it.
// R21 - After reset counting is stopped and no pulses are driven.
`timescale 1ns/100ps
`default_nettype none
`include "tpw_regs.svh"

module tpw_pwm_top
    import tpw_pkg::*;
#(
    parameter int CW = 16
)(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    input  wire logic        trigger_input_pin_i,
    input  wire logic        irq_accept_i,
    output var  logic        pulse_output_pin_o,
    output var  logic        irq_req_o
);

    // ==========================================================
    // Register bus decode
    tpw_mode_t        mode_r;
    logic             start_r;
    logic [CW-1:0]    reload_r;
    logic [CW-1:0]    cnt_r;
    logic [CW-1:0]    act_r;
    logic [7:0]       pre_r;
    tpw_state_t       st_r;
    tpw_state_t       st_nxt;

    wire bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr    = bus_req && wb_we_i;
    wire wr_mode   = bus_wr && wb_sel_i[0] && wb_adr_i == `TPW_ADR_MODE;
    wire wr_start  = bus_wr && wb_sel_i[0] && wb_adr_i == `TPW_ADR_START;
    wire wr_irq    = bus_wr && wb_sel_i[0] && wb_adr_i == `TPW_ADR_IRQ;
    wire wr_data   = bus_wr && wb_adr_i == `TPW_ADR_DATA;
    wire running   = (st_r == TPW_RUN);

    wire [CW-1:0] data_wr;
    assign data_wr = {wb_sel_i[1] ? wb_dat_i[15:8] : reload_r[15:8],
                      wb_sel_i[0] ? wb_dat_i[7:0]  : reload_r[7:0]};

    tpw_mode_t mode_wr;
    assign mode_wr = tpw_mode_t'(wb_dat_i[7:0]);

    wire start_nxt = wr_start ? wb_dat_i[0] : start_r;
    wire start_wr1 = wr_start && wb_dat_i[0];

    // Unmapped offsets answer with zero
    logic [31:0] rd_mux;
    always_comb
    begin
        case (wb_adr_i)
            `TPW_ADR_MODE:  rd_mux = {24'h000000, mode_r};
            `TPW_ADR_START: rd_mux = {31'h0, start_r};
            // Data reads are unspecified; the live count is shown
            `TPW_ADR_DATA:  rd_mux = {16'h0000, cnt_r};
            `TPW_ADR_IRQ:   rd_mux = {31'h0, irq_req_o};
            `TPW_ADR_STAT:  rd_mux = {30'h0, pulse_output_pin_o,
                                      running};
            default:        rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_mux : 32'h00000000;
        end
    end

    // ==========================================================
    // Count source and trigger pin
    logic tick;

    tpw_clk_div u_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .src_i  (mode_r.src),
        .tick_o (tick)
    );

    logic [2:0] pin_sync_r;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pin_sync_r <= 3'h0;
        else
            pin_sync_r <= {pin_sync_r[1:0], trigger_input_pin_i};
    end

    // Edge seen between second and third stage only
    wire pin_rise  = pin_sync_r[1] && !pin_sync_r[2];
    wire pin_fall  = !pin_sync_r[1] && pin_sync_r[2];
    wire pin_edge  = mode_r.trig[`TPW_TRIG_POL] ? pin_rise : pin_fall; // see R04
    wire ext_sel   = mode_r.trig[`TPW_TRIG_EXT]; // see R02
    wire pwm_mode  = (mode_r.opm == `TPW_OPM_PWM);

    // ==========================================================
    // Modulator lengths
    wire [CW-1:0] hi_len  = mode_r.wide8 ? {8'h00, reload_r[15:8]}
                                         : reload_r; // see R11 R12
    wire [CW-1:0] act_hi  = mode_r.wide8 ? {8'h00, act_r[15:8]} : act_r;
    wire [CW-1:0] per_len = mode_r.wide8 ? `TPW_PER8 : `TPW_PER16;
    wire          hi_nz   = (hi_len != 16'h0000); // see R13
    wire          unit    = tick && (!mode_r.wide8 || pre_r == 8'h00);
    wire          ph_end  = (cnt_r <= 16'h0001);

    wire trig_raw  = ext_sel ? (start_r && pin_edge) // see R05
                             : start_wr1; // see R03
    // Running channel ignores triggers
    wire trig_acc  = pwm_mode && !running && hi_nz && trig_raw; // see R06
    wire stop_req  = running && (!start_nxt || !pwm_mode);
    wire stop_irq  = running && !start_nxt && pwm_mode
                     && pulse_output_pin_o; // see R17
    wire fall_ev   = running && !stop_req && unit && ph_end
                     && pulse_output_pin_o; // see R09
    wire rise_ev   = running && !stop_req && unit && ph_end
                     && !pulse_output_pin_o;
    wire mode_ev   = wr_mode && mode_wr.opm == `TPW_OPM_PWM
                     && (mode_r.opm == `TPW_OPM_TIMER
                     || mode_r.opm == `TPW_OPM_EVENT); // see R18

    always_comb
    begin
        case (st_r)
            TPW_STOP: st_nxt = trig_acc ? TPW_RUN : TPW_STOP; // see R08
            TPW_RUN:  st_nxt = stop_req ? TPW_STOP : TPW_RUN;
            default:  st_nxt = TPW_STOP;
        endcase
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_r   <= tpw_mode_t'(`TPW_MODE_RST);
            start_r  <= 1'b0; // see R21
            reload_r <= `TPW_DATA_RST;
        end
        else
        begin
            if (wr_mode)
                mode_r <= mode_wr;
            start_r <= start_nxt;
            if (wr_data)
                reload_r <= data_wr; // see R15
        end
    end

    // Set wins over any clear in the same cycle
    wire irq_set = fall_ev || stop_irq || mode_ev;
    wire irq_clr = irq_accept_i || (wr_irq && !wb_dat_i[0]);
    wire irq_wr1 = wr_irq && wb_dat_i[0];

    // ==========================================================
    // Modulator
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r               <= TPW_STOP; // see R21
            cnt_r              <= `TPW_DATA_RST;
            act_r              <= `TPW_DATA_RST;
            pre_r              <= 8'h00;
            pulse_output_pin_o <= 1'b0;
            irq_req_o          <= 1'b0;
        end
        else
        begin
            st_r      <= st_nxt;
            irq_req_o <= irq_set || irq_wr1 || (irq_req_o && !irq_clr);
            if (!pwm_mode || stop_req)
                pulse_output_pin_o <= 1'b0; // see R07 R17
            if (wr_data && !running)
                cnt_r <= data_wr; // see R15
            if (trig_acc)
            begin
                act_r <= reload_r;
                pre_r <= reload_r[7:0];
                cnt_r <= hi_len;
                // 8-bit start spends one high time low first
                pulse_output_pin_o <= !mode_r.wide8; // see R08 R14
            end
            else if (running && !stop_req && tick)
            begin
                pre_r <= (pre_r == 8'h00) ? act_r[7:0]
                                          : pre_r - 8'h01; // see R12
                if (fall_ev)
                begin
                    pulse_output_pin_o <= 1'b0;
                    cnt_r <= per_len - act_hi; // see R11 R12
                end
                else if (rise_ev)
                begin
                    act_r <= reload_r; // see R10
                    pre_r <= reload_r[7:0];
                    cnt_r <= hi_nz ? hi_len : per_len;
                    // A zero value leaves the output parked low
                    pulse_output_pin_o <= hi_nz; // see R13
                end
                else if (unit)
                    cnt_r <= cnt_r - 16'h0001;
            end
        end
    end

    // ==========================================================
    // Checks
    chk_zero_no_run: assert property ( // see R13
        @(posedge clk_i) disable iff (rst_i)
        !running && trig_raw && !hi_nz |=> !running && !pulse_output_pin_o)
        else $error("zero value started the modulator");

    chk_fall_sets_irq: assert property ( // see R09
        @(posedge clk_i) disable iff (rst_i)
        // Leaving PWM mode drops the output without a request
        $fell(pulse_output_pin_o) && pwm_mode |-> irq_req_o)
        else $error("falling output did not set request");

    chk_busy_ignore: assert property ( // see R06
        @(posedge clk_i) disable iff (rst_i)
        running && trig_raw && !tick && !stop_req
        |=> $stable(cnt_r) && $stable(pulse_output_pin_o))
        else $error("trigger disturbed running output");

    chk_stop_falls: assert property ( // see R17
        @(posedge clk_i) disable iff (rst_i)
        stop_irq |=> !pulse_output_pin_o && !running && irq_req_o)
        else $error("stop from high did not fall and flag");

    chk_mode_sets_irq: assert property ( // see R18
        @(posedge clk_i) disable iff (rst_i)
        mode_ev |=> irq_req_o)
        else $error("mode switch did not set request");

    chk_ext_gate: assert property ( // see R05
        @(posedge clk_i) disable iff (rst_i)
        ext_sel && !start_r && !running && !wr_start |=> !running)
        else $error("pin edge accepted with start clear");

    chk_eight_low_first: assert property ( // see R14
        @(posedge clk_i) disable iff (rst_i)
        trig_acc && mode_r.wide8 |=> running && !pulse_output_pin_o)
        else $error("8-bit start did not hold low");

    chk_sixteen_start: assert property ( // see R08
        @(posedge clk_i) disable iff (rst_i)
        trig_acc && !mode_r.wide8 |=> running && pulse_output_pin_o
            && cnt_r == $past(hi_len))
        else $error("16-bit start did not raise output");

    chk_not_pwm_low: assert property ( // see R07
        @(posedge clk_i) disable iff (rst_i)
        !pwm_mode |=> !pulse_output_pin_o)
        else $error("output high outside PWM mode");

    chk_reload_rise: assert property ( // see R10
        @(posedge clk_i) disable iff (rst_i)
        rise_ev && hi_nz |=> act_r == $past(reload_r)
            && pulse_output_pin_o && running)
        else $error("rising edge missed the reload");

    chk_write_stopped: assert property ( // see R15
        @(posedge clk_i) disable iff (rst_i)
        wr_data && !running && !trig_acc |=> cnt_r == reload_r)
        else $error("stopped write did not load counter");

    chk_ack_single: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    chk_zero_parks_low: assert property ( // see R13
        @(posedge clk_i) disable iff (rst_i)
        rise_ev && !hi_nz |=> running && !pulse_output_pin_o
            && cnt_r == $past(per_len))
        else $error("zero value did not park output low");

    chk_half_tick: assert property ( // see R01
        @(posedge clk_i) disable iff (rst_i)
        mode_r.src == 2'b00 && tick && !wr_mode |=> !tick ##1 tick)
        else $error("divide by two source has wrong rate");

    chk_prescale_hold: assert property ( // see R12
        @(posedge clk_i) disable iff (rst_i)
        running && mode_r.wide8 && tick && pre_r != 8'h00 && !stop_req
        |=> $stable(cnt_r))
        else $error("counter moved inside a prescale unit");

    chk_count_down: assert property ( // see R08 R11
        @(posedge clk_i) disable iff (rst_i)
        running && !stop_req && unit && !ph_end
        |=> cnt_r == $past(cnt_r) - 16'h0001)
        else $error("counter did not step down on a unit");

    chk_fall_low_len: assert property ( // see R11 R12
        @(posedge clk_i) disable iff (rst_i)
        fall_ev |=> !pulse_output_pin_o
            && cnt_r == $past(per_len) - $past(act_hi))
        else $error("low phase length not period minus high");

    chk_run_write: assert property ( // see R15
        @(posedge clk_i) disable iff (rst_i)
        running && wr_data && !unit |=> $stable(cnt_r))
        else $error("running write touched the counter");

    chk_irq_held: assert property ( // see R09
        @(posedge clk_i) disable iff (rst_i)
        irq_req_o && !irq_clr |=> irq_req_o)
        else $error("request bit dropped without a clear");

endmodule // tpw_pwm_top
`default_nettype wire

// file: dv/tpw_far_end.sv
// Far-side model: drives the trigger pin and times the pulse phases
`timescale 1ns/100ps
`default_nettype none

module tpw_far_end (
    input  wire logic        clk_i,
    input  wire logic        lvl_i,
    input  wire logic        pulse_i,
    output wire logic        trig_o,
    output var  logic [15:0] hi_o,
    output var  logic [15:0] lo_o
);
    // ==========================================================
    // Pin drive and phase timing
    logic [15:0] cnt_r = 16'h0000;
    logic        prev_r = 1'b0;

    // Pin is a pure input of the channel, driven only from here
    assign trig_o = lvl_i;

    always @(posedge clk_i)
    begin
        prev_r <= pulse_i;
        if (pulse_i != prev_r)
        begin
            cnt_r <= 16'h0001;
            if (prev_r)
                hi_o <= cnt_r;
            else
                lo_o <= cnt_r;
        end
        else
            cnt_r <= cnt_r + 16'h0001;
    end
endmodule // tpw_far_end

`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the PWM channel
`timescale 1ns/100ps
`default_nettype none
`include "tpw_regs.svh"

`define CHK(g, e) \
    begin \
        checks++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("ERROR t=%0t got %0h want %0h", $time, (g), (e)); \
        end \
    end

module tb_top;
    // ==========================================================
    // Signals
    logic        clk_i, rst_i, cyc, stb, we, acc, lvl;
    logic        ack, pulse, irq, trig;
    logic [31:0] dat_o, wdat, q;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [15:0] hi, lo;
    int          miscompares = 0;
    int          checks = 0;
    int          cycles = 0;
    int          n;
    int          divs [4] = '{2, 16, 64, 512};

    tpw_pwm_top DUT (
        .clk_i               (clk_i),
        .rst_i               (rst_i),
        .wb_cyc_i            (cyc),
        .wb_stb_i            (stb),
        .wb_we_i             (we),
        .wb_adr_i            (adr),
        .wb_sel_i            (sel),
        .wb_dat_i            (wdat),
        .wb_dat_o            (dat_o),
        .wb_ack_o            (ack),
        .trigger_input_pin_i (trig),
        .irq_accept_i        (acc),
        .pulse_output_pin_o  (pulse),
        .irq_req_o           (irq)
    );

    tpw_far_end far (
        .clk_i   (clk_i),
        .lvl_i   (lvl),
        .pulse_i (pulse),
        .trig_o  (trig),
        .hi_o    (hi),
        .lo_o    (lo)
    );

    // ==========================================================
    // Clock, watchdog and closing
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic print_verdict();
        if (miscompares == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            $display("ERROR t=%0t timeout", $time);
            print_verdict();
        end
    end

    // ==========================================================
    // Bus cycle and waits
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (ack !== 1'b1 && k < 50);
        `CHK(ack, 1'b1)
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wait_lvl(input logic v, input int mx);
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pulse !== v && n < mx);
    endtask

    // ==========================================================
    // Sequence
    initial
    begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        acc = 1'b0;
        lvl = 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Status rather than data is read back; data reads are undefined
        xfer(`TPW_ADR_STAT, 1'b0, 32'h0);
        `CHK(q[1:0], 2'b00)
        `CHK(irq, 1'b0)
        xfer(`TPW_ADR_MODE, 1'b1, 32'h03);
        `CHK(irq, 1'b1)
        `CHK(pulse, 1'b0)
        xfer(`TPW_ADR_IRQ, 1'b1, 32'h0);
        `CHK(irq, 1'b0)
        xfer(8'hfc, 1'b0, 32'h0);
        `CHK(q, 32'h0)
        xfer(`TPW_ADR_DATA, 1'b1, 32'h0);
        xfer(`TPW_ADR_START, 1'b1, 32'h1);
        wait_lvl(1'b1, 100);
        `CHK(pulse, 1'b0)
        `CHK(irq, 1'b0)
        xfer(`TPW_ADR_START, 1'b1, 32'h0);
        // Every count source, both internal trigger codes, n = 2
        for (int s = 0; s < 4; s++)
        begin
            xfer(`TPW_ADR_MODE, 1'b1, {24'h0, s[1:0], 2'b00, s[0], 3'b011});
            xfer(`TPW_ADR_DATA, 1'b1, 32'h2);
            xfer(`TPW_ADR_IRQ, 1'b1, 32'h0);
            xfer(`TPW_ADR_START, 1'b1, 32'h1);
            `CHK(pulse, 1'b1)
            wait_lvl(1'b0, 2 * divs[s] + 8);
            @(posedge clk_i);
            `CHK(hi >= divs[s] && hi <= 2 * divs[s] + 1, 1'b1)
            `CHK(irq, 1'b1)
            xfer(`TPW_ADR_IRQ, 1'b1, 32'h0);
            xfer(`TPW_ADR_START, 1'b1, 32'h0);
            `CHK(irq, 1'b0)
            `CHK(pulse, 1'b0)
        end
        // 8-bit, n = 2 and m = 1: one unit is four clocks
        xfer(`TPW_ADR_MODE, 1'b1, 32'h23);
        xfer(`TPW_ADR_DATA, 1'b1, 32'h0201);
        xfer(`TPW_ADR_IRQ, 1'b1, 32'h0);
        xfer(`TPW_ADR_START, 1'b1, 32'h1);
        wait_lvl(1'b1, 20);
        `CHK(n >= 4 && n <= 9, 1'b1)
        wait_lvl(1'b0, 20);
        @(posedge clk_i);
        `CHK(hi, 16'h0008)
        xfer(`TPW_ADR_START, 1'b1, 32'h1);
        xfer(`TPW_ADR_DATA, 1'b1, 32'h0401);
        wait_lvl(1'b1, 1100);
        @(posedge clk_i);
        `CHK(lo, 16'h03f4)
        wait_lvl(1'b0, 40);
        @(posedge clk_i);
        `CHK(hi, 16'h0010)
        `CHK(irq, 1'b1)
        acc <= 1'b1;
        @(posedge clk_i);
        acc <= 1'b0;
        @(posedge clk_i);
        `CHK(irq, 1'b0)
        wait_lvl(1'b1, 1100);
        xfer(`TPW_ADR_START, 1'b1, 32'h0);
        `CHK(pulse, 1'b0)
        `CHK(irq, 1'b1)
        xfer(`TPW_ADR_STAT, 1'b0, 32'h0);
        `CHK(q[0], 1'b0)
        // Pin trigger, falling then rising polarity
        for (int p = 0; p < 2; p++)
        begin
            lvl <= ~p[0];
            xfer(`TPW_ADR_MODE, 1'b1, {24'h0, 3'b000, 1'b1, p[0], 3'b011});
            xfer(`TPW_ADR_DATA, 1'b1, 32'h0003);
            lvl <= p[0];
            wait_lvl(1'b1, 12);
            `CHK(pulse, 1'b0)
            xfer(`TPW_ADR_START, 1'b1, 32'h1);
            lvl <= ~p[0];
            wait_lvl(1'b1, 12);
            `CHK(pulse, 1'b0)
            lvl <= p[0];
            wait_lvl(1'b1, 12);
            `CHK(pulse, 1'b1)
            xfer(`TPW_ADR_START, 1'b1, 32'h0);
        end
        print_verdict();
    end
endmodule // tb_top

`default_nettype wire
